/* rtl/gdpd_pkg.sv */
// Contract
// - after reset saturation detect is on, pin current select code 01.
// - saturation threshold select resets to 1010, a 6.0 V trip.
// - saturation filter select resets to 01, 80 ns filter.
// - saturation blanking select resets to 011, 240 ns blanking.
// - two-level turn-off enabled at reset, intermediate level code 011.
// - two-level turn-off lasts 500 ns: filter code 100, fast filter bit one.
// - soft shutdown enabled at reset, current select code 100.
// - soft shutdown duration code 100, 3000 ns with timebase divide at one.
// - deadtime and serial error masks reset to one, both reported.
// - watchdog, internal comm and config checksum masks reset to one.
// - reference undervoltage always reported, latches gate outputs off.
// - mirror short, mirror overcurrent, segmented drive, collector clamp reset off.
// - negative supply, overtemp shutdown, warning, coherency masks reset zero.
// - other writes discarded until configuration enable is one; it stops PWM.
// - in configuration mode all settings writable, applied at chip-select rise.
// - every unmasked fault shows on fault pins and status bits; the code drives each pin only for unmaskable bits and bits set in its own pin mask.
// - latched faults clear by reset, soft reset, self test or write-one, when gone.
// - masked fault leaves PWM running, not latched, not reported.
// - gate regulator undervoltage: low side on; latch option keeps PWM off.
// - die overtemperature unmaskable: PWM off, low side and clamp on.
// - unmasked serial error latched and reported, PWM stays enabled.
package gdpd_pkg;

   typedef struct packed {
      logic vref_uv;
      logic gate_regulator_undervoltage_fault;
      logic die_overtemp_shutdown_fault;
      logic gate_supply_ov;
      logic low_side_supply_ov;
      logic deadtime;
      logic serial_message_error_fault;
      logic watchdog;
      logic comm_error;
      logic config_checksum;
      logic negative_supply_range;
      logic device_overtemp_shutdown;
      logic device_overtemp_warning;
      logic gate_coherency;
   } gdpd_fault_t;

   typedef struct packed {
      logic [1:0] sat_pin_current_select;
      logic [3:0] saturation_threshold_select;
      logic [1:0] saturation_filter_select;
      logic [2:0] saturation_blanking_select;
      logic [2:0] intermediate_gate_level_select;
      logic [2:0] short_circuit_filter_select;
      logic fast_filter_bit;
      logic [2:0] soft_shutdown_current_select;
      logic [2:0] soft_shutdown_duration_select;
      logic timebase_divide;
   } gdpd_prot_t;

   typedef struct packed {
      logic saturation_detect_enable;
      logic two_level_turnoff_enable;
      logic soft_shutdown_enable;
      logic mirror_short_circuit_enable;
      logic mirror_overcurrent_enable;
      logic segmented_drive_enable;
      logic active_collector_clamp_enable;
      logic undervoltage_latch_option;
      logic miller_clamp_enable;
   } gdpd_mode_t;

   typedef enum logic [2:0] {
      GDPD_SEL_MODE,
      GDPD_SEL_PROT,
      GDPD_SEL_MASK,
      GDPD_SEL_PRIMARY_PIN_MASK,
      GDPD_SEL_SECONDARY_PIN_MASK
   } gdpd_sel_t;

   localparam gdpd_prot_t GDPD_PROT_RESET = '{
      sat_pin_current_select: 2'h1,
      saturation_threshold_select: 4'hA,
      saturation_filter_select: 2'h1,
      saturation_blanking_select: 3'h3,
      intermediate_gate_level_select: 3'h3,
      short_circuit_filter_select: 3'h4,
      fast_filter_bit: 1'h1,
      soft_shutdown_current_select: 3'h4,
      soft_shutdown_duration_select: 3'h4,
      timebase_divide: 1'h1
   };

   localparam gdpd_mode_t GDPD_MODE_RESET = '{
      saturation_detect_enable: 1'h1,
      two_level_turnoff_enable: 1'h1,
      soft_shutdown_enable: 1'h1,
      mirror_short_circuit_enable: 1'h0,
      mirror_overcurrent_enable: 1'h0,
      segmented_drive_enable: 1'h0,
      active_collector_clamp_enable: 1'h0,
      undervoltage_latch_option: 1'h0,
      miller_clamp_enable: 1'h1
   };

   // order follows gdpd_fault_t from vref_uv down to gate_coherency
   localparam gdpd_fault_t GDPD_MASK_RESET = 14'h3FF0;
   // reference undervoltage and die overtemperature cannot be masked
   localparam gdpd_fault_t GDPD_UNMASKABLE = 14'h2800;
   // faults whose unmasked reaction blocks PWM (held until cleared)
   localparam gdpd_fault_t GDPD_BLOCKING = 14'h2E10;
   localparam logic GDPD_CONFIG_EN_RESET = 1'h0;

endpackage : gdpd_pkg

/* rtl/gdpd_protection.sv */
`timescale 1ns/10ps
module gdpd_protection
   import gdpd_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic clock_en,
   // host pin
   input wire logic chip_select_n,
   // decoded serial writes, same clock
   input wire logic wr_strobe,
   input wire gdpd_sel_t wr_sel,
   input wire gdpd_mode_t wr_mode,
   input wire gdpd_prot_t wr_prot,
   input wire gdpd_fault_t wr_mask,
   input wire logic cfg_en_wr,
   input wire logic cfg_en_data,
   input wire gdpd_fault_t clear_req,
   input wire logic soft_reset,
   input wire logic self_test,
   // analog fault comparators, asynchronous
   input wire gdpd_fault_t fault_in,
   // settings in force
   output gdpd_prot_t prot_settings,
   output gdpd_mode_t mode_settings,
   output gdpd_fault_t fault_mask,
   output logic config_enable,
   // status and pins
   output gdpd_fault_t fault_status,
   output logic primary_fault_pin_n,
   output logic secondary_fault_pin_n,
   // gate reaction
   output logic pwm_enable,
   output logic low_side_gate_driver,
   output logic miller_clamp
);

   function automatic gdpd_fault_t effective_mask(input gdpd_fault_t m);
      effective_mask = m | GDPD_UNMASKABLE;
   endfunction : effective_mask

   function automatic logic any_pin_fault(input gdpd_fault_t latched,
                                          input gdpd_fault_t pin_mask);
      any_pin_fault = |(latched & effective_mask(pin_mask));
   endfunction : any_pin_fault

   // chip select and fault comparator synchronisers
   logic cs_meta;
   logic cs_sync;
   logic cs_prev;
   gdpd_fault_t fault_meta;
   gdpd_fault_t fault_sync;

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         cs_meta <= 1'h1;
         cs_sync <= 1'h1;
         cs_prev <= 1'h1;
      end else if (clock_en) begin
         cs_meta <= chip_select_n;
         cs_sync <= cs_meta;
         cs_prev <= cs_sync;
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         fault_meta <= '0;
         fault_sync <= '0;
      end else if (clock_en) begin
         fault_meta <= fault_in;
         fault_sync <= fault_meta;
      end
   end

   // commit point: staged writes become active on the chip-select rise
   wire cs_rise = cs_sync & ~cs_prev;
   wire back_to_defaults = soft_reset | self_test;

   // shadow copies, loaded by writes and copied out at the commit point
   gdpd_mode_t shadow_mode;
   gdpd_prot_t shadow_prot;
   gdpd_fault_t shadow_mask;
   gdpd_fault_t shadow_primary_mask;
   gdpd_fault_t shadow_secondary_mask;
   logic shadow_config_en;

   // config enable must already be in force; a write in the same frame
   // that sets it is still dropped, which is what the host sequence expects
   wire write_allowed = wr_strobe & config_enable;
   wire wr_mode_hit = write_allowed & (wr_sel == GDPD_SEL_MODE);
   wire wr_prot_hit = write_allowed & (wr_sel == GDPD_SEL_PROT);
   wire wr_mask_hit = write_allowed & (wr_sel == GDPD_SEL_MASK);
   wire wr_pmask_hit = write_allowed & (wr_sel == GDPD_SEL_PRIMARY_PIN_MASK);
   wire wr_smask_hit = write_allowed & (wr_sel == GDPD_SEL_SECONDARY_PIN_MASK);

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         shadow_config_en <= GDPD_CONFIG_EN_RESET;
      end else if (clock_en) begin
         if (back_to_defaults) begin
            shadow_config_en <= GDPD_CONFIG_EN_RESET;
         end else if (cfg_en_wr) begin
            shadow_config_en <= cfg_en_data;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         shadow_mode <= GDPD_MODE_RESET;
         shadow_prot <= GDPD_PROT_RESET;
      end else if (clock_en) begin
         if (back_to_defaults) begin
            shadow_mode <= GDPD_MODE_RESET;
            shadow_prot <= GDPD_PROT_RESET;
         end else begin
            if (wr_mode_hit) begin
               shadow_mode <= wr_mode;
            end
            if (wr_prot_hit) begin
               shadow_prot <= wr_prot;
            end
         end
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         shadow_mask <= GDPD_MASK_RESET;
         shadow_primary_mask <= GDPD_MASK_RESET;
         shadow_secondary_mask <= GDPD_MASK_RESET;
      end else if (clock_en) begin
         if (back_to_defaults) begin
            shadow_mask <= GDPD_MASK_RESET;
            shadow_primary_mask <= GDPD_MASK_RESET;
            shadow_secondary_mask <= GDPD_MASK_RESET;
         end else begin
            if (wr_mask_hit) begin
               shadow_mask <= wr_mask;
            end
            if (wr_pmask_hit) begin
               shadow_primary_mask <= wr_mask;
            end
            if (wr_smask_hit) begin
               shadow_secondary_mask <= wr_mask;
            end
         end
      end
   end

   // active settings
   gdpd_fault_t primary_pin_mask;
   gdpd_fault_t secondary_pin_mask;

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         mode_settings <= GDPD_MODE_RESET;
         prot_settings <= GDPD_PROT_RESET;
         config_enable <= GDPD_CONFIG_EN_RESET;
      end else if (clock_en) begin
         if (back_to_defaults) begin
            mode_settings <= GDPD_MODE_RESET;
            prot_settings <= GDPD_PROT_RESET;
            config_enable <= GDPD_CONFIG_EN_RESET;
         end else if (cs_rise) begin
            mode_settings <= shadow_mode;
            prot_settings <= shadow_prot;
            config_enable <= shadow_config_en;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         fault_mask <= GDPD_MASK_RESET;
         primary_pin_mask <= GDPD_MASK_RESET;
         secondary_pin_mask <= GDPD_MASK_RESET;
      end else if (clock_en) begin
         if (back_to_defaults) begin
            fault_mask <= GDPD_MASK_RESET;
            primary_pin_mask <= GDPD_MASK_RESET;
            secondary_pin_mask <= GDPD_MASK_RESET;
         end else if (cs_rise) begin
            fault_mask <= shadow_mask;
            primary_pin_mask <= shadow_primary_mask;
            secondary_pin_mask <= shadow_secondary_mask;
         end
      end
   end

   // fault latching
   wire gdpd_fault_t live_mask = effective_mask(fault_mask);
   wire gdpd_fault_t fault_set = fault_sync & live_mask;
   // a clear only lands on a bit whose condition has gone away
   wire gdpd_fault_t fault_gone = ~fault_sync;
   wire gdpd_fault_t clear_hit = (clear_req | {$bits(gdpd_fault_t){back_to_defaults}})
      & fault_gone;
   // set wins over a clear in the same cycle
   wire gdpd_fault_t next_fault_status = (fault_status & ~clear_hit) | fault_set;

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         fault_status <= '0;
      end else if (clock_en) begin
         fault_status <= next_fault_status;
      end
   end

   // gate reaction
   wire gdpd_fault_t blocking_latched = next_fault_status & GDPD_BLOCKING;
   wire uv_live = fault_sync.gate_regulator_undervoltage_fault
      & live_mask.gate_regulator_undervoltage_fault;
   // latch option keeps PWM off after recovery until the bit is cleared
   wire uv_latched = next_fault_status.gate_regulator_undervoltage_fault
      & mode_settings.undervoltage_latch_option;
   wire uv_block = uv_live | uv_latched;
   wire fault_block = (|blocking_latched) | uv_block;
   // configuration mode stops switching but is no fault: low side stays idle
   wire next_pwm_enable = ~fault_block & ~config_enable;
   // hard turn-off only: no soft shutdown or two-level step for these faults
   wire next_low_side = fault_block;
   wire next_clamp = fault_block & mode_settings.miller_clamp_enable;

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         pwm_enable <= 1'h0;
         low_side_gate_driver <= 1'h0;
         miller_clamp <= 1'h0;
      end else if (clock_en) begin
         pwm_enable <= next_pwm_enable;
         low_side_gate_driver <= next_low_side;
         miller_clamp <= next_clamp;
      end
   end

   // fault pins, low while any routed latched fault stands
   wire next_primary_n = ~any_pin_fault(next_fault_status, primary_pin_mask);
   wire next_secondary_n = ~any_pin_fault(next_fault_status, secondary_pin_mask);

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         primary_fault_pin_n <= 1'h1;
         secondary_fault_pin_n <= 1'h1;
      end else if (clock_en) begin
         primary_fault_pin_n <= next_primary_n;
         secondary_fault_pin_n <= next_secondary_n;
      end
   end

endmodule : gdpd_protection

/* dv/gdpd_protection_assertions.sv */
`timescale 1ns/10ps
module gdpd_checker
   import gdpd_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // host side and fault comparators
   input wire logic soft_reset,
   input wire logic self_test,
   input wire gdpd_fault_t clear_req,
   input wire gdpd_fault_t fault_in,
   // device side
   input wire gdpd_prot_t prot_settings,
   input wire gdpd_mode_t mode_settings,
   input wire gdpd_fault_t fault_mask,
   input wire logic config_enable,
   input wire gdpd_fault_t fault_status,
   input wire logic primary_fault_pin_n,
   input wire logic pwm_enable,
   input wire logic low_side_gate_driver
);
   default clocking @(posedge clock);
   endclocking
   default disable iff (sys_rst);

   reset_defaults_a: assert property ($fell(sys_rst) |->
      prot_settings == 25'b01_1010_01_011_011_100_1_100_100_1 &&
      mode_settings == 9'b111_0000_01 && fault_mask[8:0] == 9'h1F0)
      else $error("settings not at defaults after reset");
   cfg_blocks_pwm_a: assert property (config_enable |=> !pwm_enable)
      else $error("pwm allowed in configuration mode");
   locked_settings_a: assert property (!config_enable && !soft_reset && !self_test |=>
      $stable(prot_settings) && $stable(mode_settings) && $stable(fault_mask))
      else $error("settings changed outside configuration mode");
   supply_ov_react_a: assert property ($rose(fault_in.gate_supply_ov) &&
      fault_mask.gate_supply_ov |-> ##[2:4] (fault_status.gate_supply_ov &&
      !primary_fault_pin_n && !pwm_enable && low_side_gate_driver))
      else $error("overvoltage reaction missing");
   masked_quiet_a: assert property ((fault_status & ~$past(fault_status) &
      ~$past(fault_mask) & ~14'h2800) == '0)
      else $error("masked fault latched");
   clear_cause_a: assert property (!$past(soft_reset) && !$past(self_test) |->
      ($past(fault_status) & ~fault_status & ~$past(clear_req)) == '0)
      else $error("status bit dropped without clear");
   clear_refused_a: assert property (fault_status.gate_supply_ov &&
      clear_req.gate_supply_ov && fault_in.gate_supply_ov &&
      $past(fault_in.gate_supply_ov, 2) |=> fault_status.gate_supply_ov)
      else $error("present fault was cleared");
   unmaskable_a: assert property (fault_status.vref_uv ||
      fault_status.die_overtemp_shutdown_fault |-> !pwm_enable && low_side_gate_driver)
      else $error("unmaskable fault left pwm running");
   serial_runs_a: assert property ((fault_in == '0 && !config_enable &&
      fault_status == 14'h0080) [*4] |-> pwm_enable)
      else $error("serial error blocked pwm");
endmodule : gdpd_checker

/* dv/gdpd_host_model.sv */
`timescale 1ns/10ps
module gdpd_host_model (
   // clock and watched pins
   input wire logic clock,
   input wire logic config_enable,
   input wire logic primary_fault_pin_n,
   // chip select
   output logic chip_select_n
);
   initial chip_select_n = 1'b1;
   // select held two link periods; idle a full period so the commit lands first
   task automatic frame();
      @(posedge clock);
      #2 chip_select_n = 1'b0;
      repeat (16) @(posedge clock);
      #2 chip_select_n = 1'b1;
      repeat (8) @(posedge clock);
   endtask : frame
   function automatic logic link_ok();
      return config_enable === 1'b1 && primary_fault_pin_n === 1'b1;
   endfunction : link_ok
endmodule : gdpd_host_model

/* dv/tb_gdpd_protection.sv */
`timescale 1ns/10ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin err_total++; \
   $display("MISMATCH %s exp %h got %h", n, e, g); end end
module tb_gdpd_protection;
   import gdpd_pkg::*;
   localparam gdpd_prot_t DEF_PROT = 25'b01_1010_01_011_011_100_1_100_100_1;
   localparam gdpd_fault_t DEF_MASK = 14'h3FF0;
   logic clock = 1'b0;
   logic sys_rst = 1'b1;
   logic wr_strobe = 1'b0, cfg_en_wr = 1'b0, cfg_en_data = 1'b0;
   logic soft_reset = 1'b0, self_test = 1'b0, clock_en = 1'b1;
   gdpd_sel_t wr_sel = GDPD_SEL_MODE;
   gdpd_mode_t wr_mode = '0, exp_mode;
   gdpd_prot_t wr_prot = '0, exp_prot, prot_settings;
   gdpd_fault_t wr_mask = '0, clear_req = '0, fault_in = '0, exp_mask;
   gdpd_fault_t fault_mask, fault_status;
   gdpd_mode_t mode_settings;
   logic config_enable, primary_fault_pin_n, secondary_fault_pin_n, pwm_enable;
   logic low_side_gate_driver, miller_clamp, chip_select_n;
   int err_total = 0, tests_run = 0, cycles = 0, lat, blk;
   int fault_list[8] = '{13, 12, 11, 10, 9, 7, 3, 2};
   logic [16:0] seed = 17'd83020;

   gdpd_protection dut (.clock, .sys_rst, .clock_en, .chip_select_n, .wr_strobe,
      .wr_sel, .wr_mode, .wr_prot, .wr_mask, .cfg_en_wr, .cfg_en_data, .clear_req,
      .soft_reset, .self_test, .fault_in, .prot_settings, .mode_settings, .fault_mask,
      .config_enable, .fault_status, .primary_fault_pin_n, .secondary_fault_pin_n,
      .pwm_enable, .low_side_gate_driver, .miller_clamp);
   gdpd_host_model host (.clock, .config_enable, .primary_fault_pin_n, .chip_select_n);

   always #10 clock = ~clock;
   always @(posedge clock) begin
      cycles++;
      if (cycles == 3000) begin
         err_total++;
         tally_and_finish();
      end
   end

   function automatic logic [16:0] lfsr(input logic [16:0] s);
      return {s[15:0], s[16] ^ s[13]};
   endfunction : lfsr
   task automatic step(int n = 1);
      repeat (n) @(posedge clock);
      #2;
   endtask : step
   task automatic wr(gdpd_sel_t s);
      wr_sel = s;
      wr_strobe = 1'b1;
      step();
      wr_strobe = 1'b0;
      step();
   endtask : wr
   task automatic cfg(logic v);
      cfg_en_data = v;
      cfg_en_wr = 1'b1;
      step();
      cfg_en_wr = 1'b0;
      host.frame();
      step();
   endtask : cfg
   task automatic chk_def(string t);
      `CHK("prot", DEF_PROT, prot_settings)
      `CHK("mode", 9'b111_0000_01, mode_settings)
      `CHK("mask", DEF_MASK[8:0], fault_mask[8:0])
      `CHK("cfg", 1'b0, config_enable)
      $display("test %s done", t);
   endtask : chk_def
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : tally_and_finish

   initial begin
      step(8);
      sys_rst = 1'b0;
      step(2);
      chk_def("defaults");
      wr_prot = ~DEF_PROT;
      wr(GDPD_SEL_PROT);
      host.frame();
      step();
      `CHK("locked", DEF_PROT, prot_settings)
      cfg(1'b1);
      `CHK("link", 1'b1, host.link_ok())
      `CHK("cfg pwm", 1'b0, pwm_enable)
      exp_prot = DEF_PROT;
      exp_mode = 9'b111_0000_01;
      exp_mask = DEF_MASK;
      for (int k = 0; k < 6; k++) begin
         seed = lfsr(seed);
         wr_prot = {seed, seed[7:0]};
         wr_mode = seed[8:0];
         wr_mask = seed[13:0];
         wr(gdpd_sel_t'(k % 3));
         `CHK("before cs", exp_prot, prot_settings)
         case (k % 3)
            0: exp_mode = wr_mode;
            1: exp_prot = wr_prot;
            default: exp_mask = wr_mask;
         endcase
         host.frame();
         step();
         `CHK("mode", exp_mode, mode_settings)
         `CHK("prot", exp_prot, prot_settings)
         `CHK("mask", exp_mask, fault_mask)
      end
      cfg(1'b0);
      `CHK("exit pwm", 1'b1, pwm_enable)
      soft_reset = 1'b1;
      step();
      soft_reset = 1'b0;
      step(2);
      chk_def("soft reset");
      foreach (fault_list[j]) begin
         int i;
         i = fault_list[j];
         lat = DEF_MASK[i] | (i == 13) | (i == 11);
         blk = lat & (i >= 9);
         fault_in[i] = 1'b1;
         step(5);
         `CHK("status", lat[0], fault_status[i])
         `CHK("pin", ~lat[0], primary_fault_pin_n)
         `CHK("pwm", ~blk[0], pwm_enable)
         `CHK("low side", blk[0], low_side_gate_driver)
         `CHK("clamp", blk[0], miller_clamp)
         `CHK("pin2", ~lat[0], secondary_fault_pin_n)
         clear_req[i] = 1'b1;
         step();
         clear_req[i] = 1'b0;
         step();
         `CHK("held", lat[0], fault_status[i])
         fault_in[i] = 1'b0;
         step(5);
         `CHK("after", ~(blk[0] & (i != 12)), pwm_enable)
         clear_req[i] = 1'b1;
         step();
         clear_req[i] = 1'b0;
         step(2);
         `CHK("cleared", 1'b0, fault_status[i])
         `CHK("recover", 1'b1, pwm_enable)
         $display("test fault %0d done", i);
      end
      // latch option set: regulator undervoltage keeps pwm off after recovery
      cfg(1'b1);
      wr_mode = 9'b111_0000_11;
      wr(GDPD_SEL_MODE);
      cfg(1'b0);
      fault_in[12] = 1'b1;
      step(5);
      fault_in[12] = 1'b0;
      step(5);
      `CHK("undervoltage_latch_option", 1'b0, pwm_enable)
      `CHK("uv low side", 1'b1, low_side_gate_driver)
      clear_req[12] = 1'b1;
      step();
      clear_req[12] = 1'b0;
      step(2);
      `CHK("uv free", 1'b1, pwm_enable)
      $display("test undervoltage_latch_option done");
      cfg(1'b1);
      // clock enable low: a self test pulse must not reach any flop
      clock_en = 1'b0;
      self_test = 1'b1;
      step();
      self_test = 1'b0;
      clock_en = 1'b1;
      step();
      `CHK("frozen", 1'b1, config_enable)
      self_test = 1'b1;
      step();
      self_test = 1'b0;
      step(2);
      chk_def("self test");
      tally_and_finish();
   end
endmodule : tb_gdpd_protection

bind gdpd_protection gdpd_checker chk (.clock, .sys_rst, .soft_reset, .self_test, .clear_req,
   .fault_in, .prot_settings, .mode_settings, .fault_mask, .config_enable, .fault_status,
   .primary_fault_pin_n, .pwm_enable, .low_side_gate_driver);
